// ==== logic/ptp_time_map.svh ====
// Register offsets, field positions and reset values of the system time counter.
// Assumes a 12-bit byte address on the register port.
`ifndef PTP_TIME_MAP_SVH
`define PTP_TIME_MAP_SVH

// ==========================================================================
// Register offsets
`define PTP_CTRL_OFS 12'h700
`define PTP_STEP_OFS 12'h704
`define PTP_SEC_OFS 12'h708
`define PTP_SUB_OFS 12'h70C
`define PTP_UPD_SEC_OFS 12'h710
`define PTP_UPD_SUB_OFS 12'h714
`define PTP_ADDEND_OFS 12'h718

// ==========================================================================
// Field positions
`define PTP_FINE_BIT 1
`define PTP_INIT_BIT 2
`define PTP_UPD_BIT 3
`define PTP_SIGN_BIT 31
`define PTP_SUB_MSB 30
`define PTP_STEP_MSB 7

// ==========================================================================
// Reset values
`define PTP_ZERO_WORD 32'h0000_0000
`define PTP_ZERO_STEP 8'h00
`define PTP_ZERO_SUB 31'h0000_0000

`endif

// ==== logic/ptp_time_pkg.sv ====
// Types shared by the system time counter and its register port.
// Assumes ptp_time_map.svh supplies all offsets and field positions.
package ptp_time_pkg;

    typedef logic [31:0] word_t;
    typedef logic [7:0] step_t;
    typedef logic [30:0] sub_t;
    typedef logic [62:0] time_mag_t;

    // Operation applied to the time value in one cycle, one-hot.
    typedef enum logic [3:0] {
        OP_HOLD = 4'h1,
        OP_STEP = 4'h2,
        OP_UPDATE = 4'h4,
        OP_INIT = 4'h8
    } time_op_t;

endpackage

// ==== logic/ptp_addend_accum.sv ====
// Frequency addend accumulator for the fine update method.
// Assumes the addend comes from a register on the same clock.
`timescale 1ns/1ps

module ptp_addend_accum #(
    parameter int WIDTH = 32
) (
    // Clock, reset and freeze
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Control
    input wire logic enable,
    input wire logic [WIDTH-1:0] addend,
    // Carry out, one cycle per overflow
    output logic overflow
);

    logic [WIDTH-1:0] acc;
    logic [WIDTH-1:0] next_acc;
    logic next_overflow;

    always_comb begin
        {next_overflow, next_acc} = {1'b0, acc} + {1'b0, addend};
        if (!enable) begin
            // The accumulator holds its phase while coarse mode is in use.
            next_acc = acc;
            next_overflow = 1'b0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            acc <= '0;
            overflow <= 1'b0;
        end else if (ce) begin
            acc <= next_acc;
            overflow <= next_overflow;
        end
    end

endmodule

// ==== logic/ptp_system_time_counter.sv ====
// Signed seconds/subseconds system time keeper with its register port.
// Assumes a single-cycle register master on mclk; reads answer one cycle later.
//
// Summary of operation
// - Add 8-bit step on every time update.
// - Coarse mode steps every clock cycle.
// - Fine mode steps only on accumulator overflow.
// - Seconds readable as 32-bit read-only word.
// - Bit 31 of low word gives sign.
// - Bits 30:0 give subseconds, 0.46 ns each.
// - Writable seconds and subseconds update values.
// - Update adds if sign bit 0, subtracts if 1.
// - Byte, half-word and word accesses accepted.
// - Step register upper 24 bits reserved.
// - Initialise loads time, bit self-clears.
// - Update applies offset, bit self-clears.
// - Select bit 1 fine, 0 coarse.
// - Addend accumulates each cycle in fine mode; overflow steps time.
`timescale 1ns/1ps
`include "ptp_time_map.svh"

module ptp_system_time_counter #(
    parameter int ADDR_W = 12,
    parameter int ADDEND_W = 32
) (
    // Clock, reset and freeze
    input wire logic mclk,
    input wire logic rst,
    input wire logic ce,
    // Register port
    input wire logic [ADDR_W-1:0] addr,
    input ptp_time_pkg::word_t wdata,
    input wire logic [3:0] byte_en,
    input wire logic wr,
    input wire logic rd,
    output ptp_time_pkg::word_t rdata
);
    import ptp_time_pkg::*;

    // ======================================================================
    // Helpers

    function automatic word_t merge_bytes(input word_t old, input word_t nw,
                                          input logic [3:0] be);
        word_t res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Sign-magnitude addition; a zero result from unlike signs is positive.
    function automatic logic [63:0] signed_add(input logic sa, input time_mag_t ma,
                                               input logic sb, input time_mag_t mb);
        logic [63:0] res;
        if (sa == sb) begin
            res = {sa, time_mag_t'(ma + mb)};
        end else if (ma >= mb) begin
            res = {sa && (ma != mb), time_mag_t'(ma - mb)};
        end else begin
            res = {sb, time_mag_t'(mb - ma)};
        end
        return res;
    endfunction

    // ======================================================================
    // State

    step_t step;
    word_t upd_sec;
    sub_t upd_sub;
    logic upd_sign;
    logic [ADDEND_W-1:0] addend;
    logic fine_sel;
    logic init_req;
    logic upd_req;
    logic sign;
    word_t sec;
    sub_t sub;

    step_t next_step;
    word_t next_upd_sec;
    sub_t next_upd_sub;
    logic next_upd_sign;
    logic [ADDEND_W-1:0] next_addend;
    logic next_fine_sel;
    logic next_init_req;
    logic next_upd_req;
    logic next_sign;
    word_t next_sec;
    sub_t next_sub;
    word_t next_rdata;

    time_op_t op;
    logic accum_ovf;
    time_mag_t mag;
    word_t ctrl_word;
    word_t wmerged;
    logic [63:0] sum;

    assign mag = {sec, sub};

    // ======================================================================
    // Addend accumulator

    ptp_addend_accum #(
        .WIDTH(ADDEND_W)
    ) u_accum (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .enable(fine_sel),
        .addend(addend),
        .overflow(accum_ovf)
    );

    // ======================================================================
    // Next-state logic

    always_comb begin
        next_step = step;
        next_upd_sec = upd_sec;
        next_upd_sub = upd_sub;
        next_upd_sign = upd_sign;
        next_addend = addend;
        next_fine_sel = fine_sel;
        next_init_req = init_req;
        next_upd_req = upd_req;
        next_sign = sign;
        next_sec = sec;
        next_sub = sub;
        next_rdata = `PTP_ZERO_WORD;
        sum = '0;

        ctrl_word = `PTP_ZERO_WORD;
        ctrl_word[`PTP_FINE_BIT] = fine_sel;
        ctrl_word[`PTP_INIT_BIT] = init_req;
        ctrl_word[`PTP_UPD_BIT] = upd_req;

        // Initialise outranks update, and either one replaces the step in
        // its cycle, so a pending request never waits on the step rate.
        if (init_req) begin
            op = OP_INIT;
        end else if (upd_req) begin
            op = OP_UPDATE;
        end else if (fine_sel ? accum_ovf : 1'b1) begin
            op = OP_STEP;
        end else begin
            op = OP_HOLD;
        end

        case (op)
            OP_INIT: begin
                next_sign = 1'b0;
                next_sec = upd_sec;
                next_sub = upd_sub;
                next_init_req = 1'b0;
            end
            OP_UPDATE: begin
                sum = signed_add(sign, mag, upd_sign, {upd_sec, upd_sub});
                {next_sign, next_sec, next_sub} = sum;
                next_upd_req = 1'b0;
            end
            OP_STEP: begin
                sum = signed_add(sign, mag, 1'b0, time_mag_t'(step));
                {next_sign, next_sec, next_sub} = sum;
            end
            OP_HOLD: begin
                next_sign = sign;
            end
            default: begin
                next_sign = sign;
            end
        endcase

        // A write that sets a request in the clearing cycle wins.
        wmerged = `PTP_ZERO_WORD;
        if (wr) begin
            case (addr)
                `PTP_CTRL_OFS: begin
                    wmerged = merge_bytes(ctrl_word, wdata, byte_en);
                    next_fine_sel = wmerged[`PTP_FINE_BIT];
                    if (wmerged[`PTP_INIT_BIT]) begin
                        next_init_req = 1'b1;
                    end
                    if (wmerged[`PTP_UPD_BIT]) begin
                        next_upd_req = 1'b1;
                    end
                end
                `PTP_STEP_OFS: begin
                    wmerged = merge_bytes(word_t'(step), wdata, byte_en);
                    next_step = wmerged[`PTP_STEP_MSB:0];
                end
                `PTP_UPD_SEC_OFS: begin
                    next_upd_sec = merge_bytes(upd_sec, wdata, byte_en);
                end
                `PTP_UPD_SUB_OFS: begin
                    wmerged = merge_bytes({upd_sign, upd_sub}, wdata, byte_en);
                    next_upd_sign = wmerged[`PTP_SIGN_BIT];
                    next_upd_sub = wmerged[`PTP_SUB_MSB:0];
                end
                `PTP_ADDEND_OFS: begin
                    next_addend = merge_bytes(addend, wdata, byte_en);
                end
                default: begin
                    wmerged = `PTP_ZERO_WORD;
                end
            endcase
        end

        // Unmapped addresses and reserved bits read as zero.
        if (rd) begin
            case (addr)
                `PTP_CTRL_OFS: next_rdata = ctrl_word;
                `PTP_STEP_OFS: next_rdata = word_t'(step);
                `PTP_SEC_OFS: next_rdata = sec;
                `PTP_SUB_OFS: next_rdata = {sign, sub};
                `PTP_UPD_SEC_OFS: next_rdata = upd_sec;
                `PTP_UPD_SUB_OFS: next_rdata = {upd_sign, upd_sub};
                `PTP_ADDEND_OFS: next_rdata = addend;
                default: next_rdata = `PTP_ZERO_WORD;
            endcase
        end
    end

    // ======================================================================
    // Registers

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            step <= `PTP_ZERO_STEP;
            upd_sec <= `PTP_ZERO_WORD;
            upd_sub <= `PTP_ZERO_SUB;
            upd_sign <= 1'b0;
            addend <= '0;
            fine_sel <= 1'b0;
            init_req <= 1'b0;
            upd_req <= 1'b0;
            sign <= 1'b0;
            sec <= `PTP_ZERO_WORD;
            sub <= `PTP_ZERO_SUB;
            rdata <= `PTP_ZERO_WORD;
        end else if (ce) begin
            step <= next_step;
            upd_sec <= next_upd_sec;
            upd_sub <= next_upd_sub;
            upd_sign <= next_upd_sign;
            addend <= next_addend;
            fine_sel <= next_fine_sel;
            init_req <= next_init_req;
            upd_req <= next_upd_req;
            sign <= next_sign;
            sec <= next_sec;
            sub <= next_sub;
            rdata <= next_rdata;
        end
    end

    // ======================================================================
    // Assertions

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    coarse_step_a: assert property (
        ce && !fine_sel && !init_req && !upd_req && !sign
        |=> mag == $past(mag) + time_mag_t'($past(step)))
        else $error("coarse mode did not advance by the step");

    fine_hold_a: assert property (
        ce && fine_sel && !accum_ovf && !init_req && !upd_req
        |=> mag == $past(mag) && sign == $past(sign))
        else $error("fine mode moved time without overflow");

    init_load_a: assert property (
        ce && init_req
        |=> !sign && sec == $past(upd_sec) && sub == $past(upd_sub))
        else $error("initialise did not load the update value");

    init_clear_a: assert property (
        ce && init_req && !wr |=> !init_req)
        else $error("initialise request did not self-clear");

    // Back-to-back writes may set the request again, so only the next cycle is checked.
    update_clear_a: assert property (
        ce && upd_req && !init_req && !wr |=> !upd_req)
        else $error("update request did not self-clear");

    update_add_a: assert property (
        ce && upd_req && !init_req && !upd_sign && !sign
        |=> mag == $past(mag) + $past({upd_sec, upd_sub}))
        else $error("positive update did not add");

    read_sec_a: assert property (
        ce && rd && addr == `PTP_SEC_OFS |=> rdata == $past(sec))
        else $error("seconds read mismatch");

    read_low_a: assert property (
        ce && rd && addr == `PTP_SUB_OFS |=> rdata == $past({sign, sub}))
        else $error("sign and subseconds read mismatch");

    step_rsvd_a: assert property (
        ce && rd && addr == `PTP_STEP_OFS |=> rdata[`PTP_SIGN_BIT:`PTP_STEP_MSB + 1] == '0)
        else $error("reserved step bits read nonzero");

    init_seen_c: cover property (ce && init_req ##1 !init_req);
    neg_update_c: cover property (ce && upd_req && upd_sign ##1 sign);
    fine_step_c: cover property (ce && fine_sel && accum_ovf && !init_req && !upd_req);

endmodule

// ==== dv/ptp_time_tb.sv ====
// Self-checking bench for the system time counter, driven over its register port.
// Assumes ptp_time_pkg and ptp_time_map.svh are compiled ahead of this file.
`timescale 1ns/1ps
`include "ptp_time_map.svh"

module testbench;
    import ptp_time_pkg::*;

    // ==========================================================================
    // Stimulus and observed signals
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic [11:0] addr = 12'h000;
    word_t wdata = 32'h0000_0000;
    logic [3:0] byte_en = 4'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    word_t rdata;
    int n_mismatch = 0;
    int checked = 0;
    word_t v0;
    word_t v1;

    ptp_system_time_counter #(.ADDR_W(12), .ADDEND_W(32)) dut (
        .mclk(mclk),
        .rst(rst),
        .ce(ce),
        .addr(addr),
        .wdata(wdata),
        .byte_en(byte_en),
        .wr(wr),
        .rd(rd),
        .rdata(rdata)
    );

    initial begin
        forever #4 mclk = ~mclk;
    end

    // ==========================================================================
    // Bus tasks and comparison
    task automatic wr_reg(input logic [11:0] a, input word_t d, input logic [3:0] be);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        byte_en <= be;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask

    // Read data are taken just after the edge that follows the strobe cycle.
    task automatic rd_reg(input logic [11:0] a, output word_t v);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic chk(input string name, input word_t seen, input word_t exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic chk_reg(input string name, input logic [11:0] a, input word_t exp);
        word_t v;
        rd_reg(a, v);
        chk(name, v, exp);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ==========================================================================
    // Watchdog: the tests need about 150 cycles, so 5000 is ample.
    initial begin
        repeat (5000) @(posedge mclk);
        n_mismatch++;
        $display("watchdog expired");
        tally_and_finish();
    end

    // ==========================================================================
    // Test sequence
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'b0;

        // Step is zero after reset, so the time stands still until the step test.
        for (int i = 0; i < 7; i++) begin
            chk_reg("reset value", 12'h700 + 12'(4 * i), 32'h0000_0000);
        end
        chk_reg("unmapped read", 12'h7FC, 32'h0000_0000);
        $display("test reset values done");

        wr_reg(`PTP_UPD_SEC_OFS, 32'hA1B2_C3D4, 4'h5);
        chk_reg("update seconds lanes 0 2", `PTP_UPD_SEC_OFS, 32'h00B2_00D4);
        wr_reg(`PTP_UPD_SEC_OFS, 32'h1122_3344, 4'hA);
        chk_reg("update seconds lanes 1 3", `PTP_UPD_SEC_OFS, 32'h11B2_33D4);
        $display("test byte lanes done");

        wr_reg(`PTP_UPD_SEC_OFS, 32'h1234_5678, 4'hF);
        wr_reg(`PTP_UPD_SUB_OFS, 32'h0000_0100, 4'hF);
        chk_reg("update subseconds", `PTP_UPD_SUB_OFS, 32'h0000_0100);
        wr_reg(`PTP_CTRL_OFS, 32'h0000_0004, 4'hF);
        chk_reg("init self clear", `PTP_CTRL_OFS, 32'h0000_0000);
        chk_reg("seconds after init", `PTP_SEC_OFS, 32'h1234_5678);
        chk_reg("subseconds after init", `PTP_SUB_OFS, 32'h0000_0100);
        wr_reg(`PTP_SEC_OFS, 32'hFFFF_FFFF, 4'hF);
        wr_reg(`PTP_SUB_OFS, 32'hFFFF_FFFF, 4'hF);
        chk_reg("seconds read only", `PTP_SEC_OFS, 32'h1234_5678);
        chk_reg("subseconds read only", `PTP_SUB_OFS, 32'h0000_0100);
        $display("test initialise done");

        // Adding 0x7FFFFF00 to 0x100 lands exactly on the subsecond rollover.
        wr_reg(`PTP_UPD_SEC_OFS, 32'h0000_0001, 4'hF);
        wr_reg(`PTP_UPD_SUB_OFS, 32'h7FFF_FF00, 4'hF);
        wr_reg(`PTP_CTRL_OFS, 32'h0000_0008, 4'hF);
        chk_reg("update self clear", `PTP_CTRL_OFS, 32'h0000_0000);
        chk_reg("seconds after add", `PTP_SEC_OFS, 32'h1234_567A);
        chk_reg("subseconds after add", `PTP_SUB_OFS, 32'h0000_0000);
        wr_reg(`PTP_UPD_SEC_OFS, 32'h0000_0000, 4'hF);
        wr_reg(`PTP_UPD_SUB_OFS, 32'h8000_0010, 4'hF);
        wr_reg(`PTP_CTRL_OFS, 32'h0000_0008, 4'hF);
        chk_reg("seconds after subtract", `PTP_SEC_OFS, 32'h1234_5679);
        chk_reg("subseconds after subtract", `PTP_SUB_OFS, 32'h7FFF_FFF0);
        $display("test offset update done");

        wr_reg(`PTP_UPD_SUB_OFS, 32'h0000_0000, 4'hF);
        wr_reg(`PTP_CTRL_OFS, 32'h0000_0004, 4'hF);
        wr_reg(`PTP_UPD_SUB_OFS, 32'h8000_0005, 4'hF);
        wr_reg(`PTP_CTRL_OFS, 32'h0000_0008, 4'hF);
        chk_reg("negative time sign", `PTP_SUB_OFS, 32'h8000_0005);
        chk_reg("negative time seconds", `PTP_SEC_OFS, 32'h0000_0000);
        wr_reg(`PTP_UPD_SUB_OFS, 32'h0000_0000, 4'hF);
        wr_reg(`PTP_CTRL_OFS, 32'h0000_0004, 4'hF);
        $display("test negative time done");

        // Successive reads are strobed two cycles apart.
        wr_reg(`PTP_STEP_OFS, 32'hFFFF_FF10, 4'hF);
        chk_reg("step reserved bits", `PTP_STEP_OFS, 32'h0000_0010);
        rd_reg(`PTP_SUB_OFS, v0);
        rd_reg(`PTP_SUB_OFS, v1);
        chk("coarse advance", v1 - v0, 32'h0000_0020);
        $display("test coarse step done");

        // Half-range addend overflows once in every two cycles.
        wr_reg(`PTP_ADDEND_OFS, 32'h8000_0000, 4'hF);
        wr_reg(`PTP_CTRL_OFS, 32'h0000_0002, 4'hF);
        chk_reg("fine select read back", `PTP_CTRL_OFS, 32'h0000_0002);
        rd_reg(`PTP_SUB_OFS, v0);
        rd_reg(`PTP_SUB_OFS, v1);
        chk("fine advance", v1 - v0, 32'h0000_0010);
        wr_reg(`PTP_ADDEND_OFS, 32'h0000_0000, 4'hF);
        repeat (4) @(posedge mclk);
        rd_reg(`PTP_SUB_OFS, v0);
        rd_reg(`PTP_SUB_OFS, v1);
        chk("fine without overflow", v1 - v0, 32'h0000_0000);
        $display("test fine step done");

        // Five frozen edges between the two reads leave three live steps of 0x10.
        wr_reg(`PTP_CTRL_OFS, 32'h0000_0000, 4'hF);
        rd_reg(`PTP_SUB_OFS, v0);
        @(posedge mclk);
        ce <= 1'b0;
        repeat (5) @(posedge mclk);
        ce <= 1'b1;
        rd_reg(`PTP_SUB_OFS, v1);
        chk("clock enable freeze", v1 - v0, 32'h0000_0030);
        $display("test clock enable done");

        // A reset in mid-run clears the time and the step, so the time stands at zero.
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        chk_reg("subseconds after reset", `PTP_SUB_OFS, 32'h0000_0000);
        chk_reg("seconds after reset", `PTP_SEC_OFS, 32'h0000_0000);
        chk_reg("step after reset", `PTP_STEP_OFS, 32'h0000_0000);
        $display("test mid-run reset done");

        tally_and_finish();
    end
endmodule
